// [design/tc_pkg.sv]
/*
 * Shared constants for the timer and counter block: clock rate, tick periods,
 * value ceilings and the word map through which current values are read back.
 * Assumes a single 200 MHz clock domain.
 */
package tc_pkg;

    // system clock and tick periods
    localparam int          CLK_FREQ_HZ    = 200_000_000;
    localparam int          MS_PER_S       = 1000;
    localparam int          FAST_TICK_MS   = 10;     // 0.01 s unit
    localparam int          SLOW_TICK_MS   = 100;    // 0.1 s unit
    localparam int          FAST_TICK_CYC  = CLK_FREQ_HZ / MS_PER_S * FAST_TICK_MS;
    localparam int          SLOW_PER_FAST  = SLOW_TICK_MS / FAST_TICK_MS;

    // widths
    localparam int          WORD_W         = 16;
    localparam int          DWORD_W        = 32;

    // value ceilings, in counts of the active unit
    localparam logic [15:0] SINGLE_MAX     = 16'h270F;      // 999.9 s or 99.99 s
    localparam logic [31:0] ACC_MAX        = 32'h05F5E0FF;  // 9999999.9 s or 999999.99 s
    localparam logic [15:0] CNT_MAX        = 16'h270F;      // 9999 counts
    localparam logic [31:0] UDC_MAX        = 32'h05F5E0FF;  // 99999999 counts
    localparam logic [15:0] STAGE_MAX      = 16'h270F;      // 9999 counts

    // word map: timers at their own number, counters offset by 1000
    localparam logic [15:0] CNT_WORD_BASE  = 16'h03E8;
    localparam logic [15:0] HI_WORD_OFS    = 16'h0001;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

endpackage

// [design/tick_if.sv]
/*
 * Carries the 10 ms and 100 ms tick enables from the tick generator to the
 * timers. Both ticks are one-cycle pulses in the clk domain.
 */
`timescale 1ns/10ps
interface tick_if;
    logic tick_fast;    // every 10 ms
    logic tick_slow;    // every 100 ms, coincides with a fast tick

    modport gen (output tick_fast, output tick_slow);
    modport use_side (input tick_fast, input tick_slow);
endinterface

// [design/tick_gen.sv]
/*
 * Divides the system clock into 10 ms and 100 ms one-cycle tick enables.
 * Assumes clk at the package rate; FAST_CYC may be shortened for simulation.
 */
`timescale 1ns/10ps
module tick_gen
    import tc_pkg::*;
#(
    parameter int FAST_CYC = FAST_TICK_CYC
)
(
    input  wire logic clk,
    input  wire logic nrst,
    tick_if.gen       tk
);

    logic [31:0] div_r;
    logic [7:0]  slow_cnt_r;
    logic        fast_r;
    logic        slow_r;

    ////////////////////////////////////////////////////////////////////////////
    // fast divider: one pulse every FAST_CYC clocks
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_r  <= 32'h0;
            fast_r <= 1'b0;
        end
        else if (div_r == 32'(FAST_CYC - 1))
        begin
            div_r  <= 32'h0;
            fast_r <= 1'b1;
        end
        else
        begin
            div_r  <= div_r + 32'h1;
            fast_r <= 1'b0;
        end
    end

    // slow tick rides on every tenth fast tick so both units stay in step
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slow_cnt_r <= 8'h0;
            slow_r     <= 1'b0;
        end
        else if (div_r == 32'(FAST_CYC - 1))
        begin
            slow_r     <= (slow_cnt_r == 8'(SLOW_PER_FAST - 1));
            slow_cnt_r <= (slow_cnt_r == 8'(SLOW_PER_FAST - 1)) ? 8'h0 : slow_cnt_r + 8'h1;
        end
        else
        begin
            slow_r <= 1'b0;
        end
    end

    assign tk.tick_fast = fast_r;
    assign tk.tick_slow = slow_r;

    ////////////////////////////////////////////////////////////////////////////
    chk_slow_on_fast: assert property (@(posedge clk) disable iff (!nrst)
        slow_r |-> fast_r) else $error("slow tick without fast tick");
    chk_fast_single_pulse: assert property (@(posedge clk) disable iff (!nrst)
        fast_r |=> !fast_r) else $error("fast tick longer than one cycle");

endmodule

// [design/timer_counter_block.sv]
/*
 * Timer and counter block: a single-input timer, an accumulating timer, an up
 * counter, an up/down counter and a stage counter, each with current value,
 * preset compare and status bit, plus a word read port over current values.
 * Assumes all inputs synchronous to clk and driven by the user ladder program.
 */
`timescale 1ns/10ps
module timer_counter_block
    import tc_pkg::*;
#(
    parameter int          FAST_CYC = FAST_TICK_CYC,
    parameter logic [15:0] TMR_SLOT = 16'h0000,
    parameter logic [15:0] ACC_SLOT = 16'h0002,
    parameter logic [15:0] CNT_NUM  = 16'h0000,
    parameter logic [15:0] UDC_NUM  = 16'h0001,
    parameter logic [15:0] STG_NUM  = 16'h0003
)
(
    input  wire  logic        clk,
    input  wire  logic        nrst,
    input  wire  logic        tmr_en,
    input  wire  logic        tmr_fast,
    input  wire  logic [15:0] tmr_preset,
    output logic        [15:0] tmr_value_r,
    output logic              tmr_status_r,
    input  wire  logic        acc_en,
    input  wire  logic        acc_rst,
    input  wire  logic        acc_fast,
    input  wire  logic [31:0] acc_preset,
    output logic        [31:0] acc_value_r,
    output logic              acc_status_r,
    input  wire  logic        cnt_in,
    input  wire  logic        cnt_rst,
    input  wire  logic [15:0] cnt_preset,
    output logic        [15:0] cnt_value_r,
    output logic              cnt_status_r,
    input  wire  logic        udc_up,
    input  wire  logic        udc_dn,
    input  wire  logic        udc_rst,
    input  wire  logic [31:0] udc_preset,
    output logic        [31:0] udc_value_r,
    output logic              udc_status_r,
    input  wire  logic        stg_in,
    input  wire  logic        stg_rst_cmd,
    input  wire  logic [15:0] stg_preset,
    output logic        [15:0] stg_value_r,
    output logic              stg_status_r,
    input  wire  logic [15:0] mem_addr,
    output logic        [15:0] mem_rdata_r
);

    tick_if tk ();

    logic        cnt_in_d_r;
    logic        udc_up_d_r;
    logic        udc_dn_d_r;
    logic        stg_in_d_r;
    logic        stg_cmd_d_r;
    logic        tmr_tick;
    logic        acc_tick;
    logic        cnt_edge;
    logic        up_edge;
    logic        dn_edge;
    logic        stg_edge;
    logic        stg_cmd_edge;
    logic [15:0] tmr_nxt;
    logic [31:0] acc_nxt;
    logic [15:0] cnt_nxt;
    logic [31:0] udc_nxt;
    logic [15:0] stg_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // tick source
    tick_gen #(.FAST_CYC(FAST_CYC)) u_tick (
        .clk  (clk),
        .nrst (nrst),
        .tk   (tk)
    );

    // each timer picks its unit; the fast variants use the 10 ms tick
    assign tmr_tick = tmr_fast ? tk.tick_fast : tk.tick_slow;
    assign acc_tick = acc_fast ? tk.tick_fast : tk.tick_slow;

    ////////////////////////////////////////////////////////////////////////////
    // previous input levels for rising-edge detection
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_in_d_r  <= 1'b0;
            udc_up_d_r  <= 1'b0;
            udc_dn_d_r  <= 1'b0;
            stg_in_d_r  <= 1'b0;
            stg_cmd_d_r <= 1'b0;
        end
        else
        begin
            cnt_in_d_r  <= cnt_in;
            udc_up_d_r  <= udc_up;
            udc_dn_d_r  <= udc_dn;
            stg_in_d_r  <= stg_in;
            stg_cmd_d_r <= stg_rst_cmd;
        end
    end

    // an input already high at reset release does not count as an edge? it does:
    // the history is cleared to low, matching a program scan starting from off
    assign cnt_edge     = cnt_in & ~cnt_in_d_r;
    assign up_edge      = udc_up & ~udc_up_d_r;
    assign dn_edge      = udc_dn & ~udc_dn_d_r;
    assign stg_edge     = stg_in & ~stg_in_d_r;
    assign stg_cmd_edge = stg_rst_cmd & ~stg_cmd_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // next values
    always_comb
    begin
        // single-input timer: input low means zero at once
        tmr_nxt = tmr_value_r;
        if (!tmr_en)
            tmr_nxt = 16'h0;
        else if (tmr_tick && tmr_value_r < SINGLE_MAX)
            tmr_nxt = tmr_value_r + 16'h1;

        // accumulating timer: reset dominates enable
        acc_nxt = acc_value_r;
        if (acc_rst)
            acc_nxt = 32'h0;
        else if (acc_en && acc_tick && acc_value_r < ACC_MAX)
            acc_nxt = acc_value_r + 32'h1;

        // up counter saturates at its ceiling
        cnt_nxt = cnt_value_r;
        if (cnt_rst)
            cnt_nxt = 16'h0;
        else if (cnt_edge && cnt_value_r < CNT_MAX)
            cnt_nxt = cnt_value_r + 16'h1;

        // up/down counter: coincident edges cancel
        udc_nxt = udc_value_r;
        if (udc_rst)
            udc_nxt = 32'h0;
        else if (up_edge && !dn_edge && udc_value_r < UDC_MAX)
            udc_nxt = udc_value_r + 32'h1;
        else if (dn_edge && !up_edge && udc_value_r != 32'h0)
            udc_nxt = udc_value_r - 32'h1;

        // stage counter ignores input levels for clearing
        stg_nxt = stg_value_r;
        if (stg_cmd_edge)
            stg_nxt = 16'h0;
        else if (stg_edge && stg_value_r < STAGE_MAX)
            stg_nxt = stg_value_r + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer values and status; status tracks the same edge as the value
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tmr_value_r  <= 16'h0;
            tmr_status_r <= 1'b0;
        end
        else
        begin
            tmr_value_r  <= tmr_nxt;
            tmr_status_r <= tmr_en && (tmr_nxt >= tmr_preset);
        end
    end

    // a zero preset would otherwise light status during reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_value_r  <= 32'h0;
            acc_status_r <= 1'b0;
        end
        else
        begin
            acc_value_r  <= acc_nxt;
            acc_status_r <= !acc_rst && (acc_nxt >= acc_preset);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // up counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_value_r  <= 16'h0;
            cnt_status_r <= 1'b0;
        end
        else
        begin
            cnt_value_r  <= cnt_nxt;
            cnt_status_r <= !cnt_rst && (cnt_nxt >= cnt_preset);
        end
    end

    // up/down counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            udc_value_r  <= 32'h0;
            udc_status_r <= 1'b0;
        end
        else
        begin
            udc_value_r  <= udc_nxt;
            udc_status_r <= !udc_rst && (udc_nxt >= udc_preset);
        end
    end

    // stage counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stg_value_r  <= 16'h0;
            stg_status_r <= 1'b0;
        end
        else
        begin
            stg_value_r  <= stg_nxt;
            stg_status_r <= !stg_cmd_edge && (stg_nxt >= stg_preset);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word read port; double words put the low half at the lower address.
    // the word after the accumulating slot is its high half, so a program that
    // reuses that slot for another timer would alias it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mem_rdata_r <= WORD_ZERO;
        else if (mem_addr == TMR_SLOT)
            mem_rdata_r <= tmr_value_r;
        else if (mem_addr == ACC_SLOT)
            mem_rdata_r <= acc_value_r[WORD_W-1:0];
        else if (mem_addr == ACC_SLOT + HI_WORD_OFS)
            mem_rdata_r <= acc_value_r[DWORD_W-1:WORD_W];
        else if (mem_addr == CNT_WORD_BASE + CNT_NUM)
            mem_rdata_r <= cnt_value_r;
        else if (mem_addr == CNT_WORD_BASE + UDC_NUM)
            mem_rdata_r <= udc_value_r[WORD_W-1:0];
        else if (mem_addr == CNT_WORD_BASE + UDC_NUM + HI_WORD_OFS)
            mem_rdata_r <= udc_value_r[DWORD_W-1:WORD_W];
        else if (mem_addr == CNT_WORD_BASE + STG_NUM)
            mem_rdata_r <= stg_value_r;
        else
            mem_rdata_r <= WORD_ZERO;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_acc_reset_clear: assert property (
        acc_rst |=> (acc_value_r == 32'h0) && !acc_status_r)
        else $error("accumulating timer not cleared by reset");
    chk_acc_ceiling: assert property (
        acc_value_r <= ACC_MAX) else $error("accumulating timer above ceiling");
    chk_acc_pause: assert property (
        (!acc_en && !acc_rst) |=> $stable(acc_value_r))
        else $error("accumulating timer moved while paused");
    chk_acc_status_cmp: assert property (
        !acc_rst |=> acc_status_r == (acc_value_r >= $past(acc_preset)))
        else $error("accumulating status disagrees with preset compare");
    chk_tmr_drop_clear: assert property (
        !tmr_en |=> (tmr_value_r == 16'h0) && !tmr_status_r)
        else $error("single timer not cleared when input dropped");
    chk_cnt_edge_inc: assert property (
        (!cnt_rst && cnt_edge && cnt_value_r < CNT_MAX)
        |=> cnt_value_r == $past(cnt_value_r) + 16'h1)
        else $error("up counter missed an edge");
    chk_cnt_level_hold: assert property (
        (!cnt_rst && !cnt_edge) |=> $stable(cnt_value_r))
        else $error("up counter moved without an edge");
    chk_cnt_reset_zero: assert property (
        cnt_rst |=> (cnt_value_r == 16'h0) && !cnt_status_r)
        else $error("up counter not cleared by reset");
    chk_cnt_ceiling: assert property (
        cnt_value_r <= CNT_MAX) else $error("up counter above 9999");
    chk_udc_tie_hold: assert property (
        (!udc_rst && up_edge && dn_edge) |=> $stable(udc_value_r))
        else $error("up/down counter moved on coincident edges");
    chk_stg_no_level_clear: assert property (
        !stg_cmd_edge |=> stg_value_r >= $past(stg_value_r))
        else $error("stage counter dropped without reset command");

endmodule

// [dv/ladder_prog.sv]
/*
 * Model of the user ladder program on the counters' far side: it makes
 * rising edges on the count inputs, or holds them at a steady level.
 * Assumes clk is the block clock. Outputs change 1 ns after its rising edge.
 */
`timescale 1ns/10ps
module ladder_prog
(
    input  wire logic clk,
    output logic      cnt_in,
    output logic      udc_up,
    output logic      udc_dn,
    output logic      stg_in
);

    ////////////////////////////////////////////////////////////////////////////////
    // idle low, so the first high is a clean edge after reset
    initial
    begin
        {cnt_in, udc_up, udc_dn, stg_in} = 4'h0;
    end

    // n edges on the inputs picked by sel {cnt, up, dn, stg}; the input stays low
    // for one cycle between highs, the tightest spacing the counters accept
    task automatic pulse(input logic [3:0] sel, input int n);
        repeat (n)
        begin
            @(posedge clk) #1 {cnt_in, udc_up, udc_dn, stg_in} = sel;
            @(posedge clk) #1 {cnt_in, udc_up, udc_dn, stg_in} = 4'h0;
        end
    endtask

    // one edge, then a steady high level for n cycles that must not count
    task automatic hold(input logic [3:0] sel, input int n);
        @(posedge clk) #1 {cnt_in, udc_up, udc_dn, stg_in} = sel;
        repeat (n) @(posedge clk);
        #1 {cnt_in, udc_up, udc_dn, stg_in} = 4'h0;
    endtask

endmodule

// [dv/testbench.sv]
/*
 * Self-checking bench for the timer and counter block: timers, counters,
 * the up counter ceiling, resets and the word read port, with seeded random counts.
 * Assumes the tick divider is shortened through FAST_CYC.
 */
`timescale 1ns/10ps
module testbench
    import tc_pkg::*;
;
    localparam int          FC = 4;                  // short fast tick, keeps the run brief
    localparam int          SC = FC * SLOW_PER_FAST; // cycles per slow unit
    localparam logic [15:0] AS = 16'h0002;
    localparam logic [15:0] US = 16'h0001;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        tmr_en = 1'b0, tmr_fast = 1'b0, acc_en = 1'b0, acc_rst = 1'b0;
    logic        acc_fast = 1'b0, cnt_rst = 1'b0, udc_rst = 1'b0, stg_rst_cmd = 1'b0;
    logic [15:0] tmr_preset = 16'h0000, cnt_preset = 16'h0000, stg_preset = 16'h0000;
    logic [31:0] acc_preset = 32'h0, udc_preset = 32'h0;
    logic [15:0] mem_addr = 16'h0000;
    logic        cnt_in, udc_up, udc_dn, stg_in;
    logic [15:0] tmr_value_r, cnt_value_r, stg_value_r, mem_rdata_r;
    logic [31:0] acc_value_r, udc_value_r;
    logic        tmr_status_r, acc_status_r, cnt_status_r, udc_status_r, stg_status_r;
    logic [31:0] seed = 32'hDD0B;
    int          mismatches = 0;
    int          tests_run = 0;
    int          n, m;

    ////////////////////////////////////////////////////////////////////////////////
    timer_counter_block #(
        .FAST_CYC (FC),
        .TMR_SLOT (16'h0000),
        .ACC_SLOT (AS),      // slot 1 left free; the wide timer takes slots 2 and 3
        .CNT_NUM  (16'h0000),
        .UDC_NUM  (US),
        .STG_NUM  (16'h0003)
    ) u_dut (
        .clk, .nrst, .tmr_en, .tmr_fast, .tmr_preset, .tmr_value_r, .tmr_status_r,
        .acc_en, .acc_rst, .acc_fast, .acc_preset, .acc_value_r, .acc_status_r,
        .cnt_in, .cnt_rst, .cnt_preset, .cnt_value_r, .cnt_status_r,
        .udc_up, .udc_dn, .udc_rst, .udc_preset, .udc_value_r, .udc_status_r,
        .stg_in, .stg_rst_cmd, .stg_preset, .stg_value_r, .stg_status_r,
        .mem_addr, .mem_rdata_r
    );

    ladder_prog u_prog (.clk, .cnt_in, .udc_up, .udc_dn, .stg_in);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    function automatic logic ge(input int v, input logic [31:0] p);
        return 32'(v) >= p;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    // k rising edges, then 1 ns so inputs never move on the sampling edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // the read port answers one cycle after the address
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
        mem_addr = a;
        step(1);
        chk(nm, e, {16'h0000, mem_rdata_r});
    endtask

    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial
    begin
        step(2);
        nrst = 1'b1;
        chk("tmr_value", 32'h0, {16'h0000, tmr_value_r});
        // single-input timer, slow then fast unit, random preset
        seed = lfsr(seed);
        n = int'(seed[2:0]) + 2;
        tmr_preset = {12'h000, seed[19:16]};
        tmr_en = 1'b1;
        // the first slow tick lands SC cycles after release and is taken one edge later
        step(n * SC + 1);
        chk("tmr_value", 32'(n), {16'h0000, tmr_value_r});
        chkb("tmr_status", ge(n, {16'h0000, tmr_preset}), tmr_status_r);
        rd(16'h0000, 32'(n), "tmr_word");
        tmr_en = 1'b0;
        step(1);
        chk("tmr_value", 32'h0, {16'h0000, tmr_value_r});
        chkb("tmr_status", 1'b0, tmr_status_r);
        tmr_fast = 1'b1;
        tmr_en = 1'b1;
        step(n * FC);
        chk("tmr_fast_value", 32'(n), {16'h0000, tmr_value_r});
        tmr_en = 1'b0;
        // accumulating timer: run two units, pause one, run one more
        acc_preset = 32'h3;
        acc_en = 1'b1;
        step(2 * SC);
        acc_en = 1'b0;
        step(SC);
        chk("acc_paused", 32'h2, acc_value_r);
        chkb("acc_status", 1'b0, acc_status_r);
        acc_en = 1'b1;
        step(SC);
        acc_en = 1'b0;
        chk("acc_value", 32'h3, acc_value_r);
        chkb("acc_status", 1'b1, acc_status_r);
        rd(AS, 32'h3, "acc_low_word");
        rd(AS + HI_WORD_OFS, 32'h0, "acc_high_word");
        // reset wins over enable, then fast unit with random preset
        acc_en = 1'b1;
        acc_rst = 1'b1;
        step(SC);
        chk("acc_reset", 32'h0, acc_value_r);
        chkb("acc_status", 1'b0, acc_status_r);
        seed = lfsr(seed);
        acc_preset = {28'h0, seed[3:0]};
        acc_rst = 1'b0;
        acc_fast = 1'b1;
        step(7 * FC);
        acc_en = 1'b0;
        chk("acc_fast_value", 32'h7, acc_value_r);
        chkb("acc_status", ge(7, acc_preset), acc_status_r);
        // up counter: random edges, steady level, reset, ceiling
        seed = lfsr(seed);
        n = int'(seed[4:0]) + 1;
        cnt_preset = {11'h000, seed[20:16]};
        u_prog.pulse(4'h8, n);
        step(1);
        chk("cnt_value", 32'(n), {16'h0000, cnt_value_r});
        chkb("cnt_status", ge(n, {16'h0000, cnt_preset}), cnt_status_r);
        u_prog.hold(4'h8, 6);
        step(1);
        chk("cnt_level", 32'(n + 1), {16'h0000, cnt_value_r});
        rd(CNT_WORD_BASE, 32'(n + 1), "cnt_word");
        cnt_rst = 1'b1;
        step(1);
        chk("cnt_reset", 32'h0, {16'h0000, cnt_value_r});
        chkb("cnt_status", 1'b0, cnt_status_r);
        cnt_rst = 1'b0;
        u_prog.pulse(4'h8, 10005);
        step(1);
        chk("cnt_ceiling", {16'h0000, CNT_MAX}, {16'h0000, cnt_value_r});
        chkb("cnt_status", 1'b1, cnt_status_r);
        // up/down counter: up, down, ties, floor at zero, words, reset
        seed = lfsr(seed);
        n = int'(seed[3:0]) + 4;
        m = int'(seed[17:16]) + 1;
        udc_preset = {28'h0, seed[11:8]};
        u_prog.pulse(4'h4, n);
        u_prog.pulse(4'h2, m);
        u_prog.pulse(4'h6, 3);
        step(1);
        chk("udc_value", 32'(n - m), udc_value_r);
        chkb("udc_status", ge(n - m, udc_preset), udc_status_r);
        rd(CNT_WORD_BASE + US, 32'(n - m), "udc_low_word");
        rd(CNT_WORD_BASE + US + HI_WORD_OFS, 32'h0, "udc_high_word");
        u_prog.pulse(4'h2, n + 2);
        step(1);
        chk("udc_floor", 32'h0, udc_value_r);
        u_prog.pulse(4'h4, 2);
        udc_rst = 1'b1;
        step(1);
        chk("udc_reset", 32'h0, udc_value_r);
        udc_rst = 1'b0;
        // stage counter: only the command edge clears it, never the level
        seed = lfsr(seed);
        n = int'(seed[3:0]) + 1;
        stg_preset = {12'h000, seed[23:20]};
        u_prog.pulse(4'h1, n);
        step(1);
        chk("stg_value", 32'(n), {16'h0000, stg_value_r});
        chkb("stg_status", ge(n, {16'h0000, stg_preset}), stg_status_r);
        stg_rst_cmd = 1'b1;
        step(1);
        chk("stg_clear", 32'h0, {16'h0000, stg_value_r});
        u_prog.pulse(4'h1, 2);
        step(1);
        chk("stg_level", 32'h2, {16'h0000, stg_value_r});
        rd(CNT_WORD_BASE + 16'h0003, 32'h2, "stg_word");
        stg_rst_cmd = 1'b0;
        // unmapped word reads zero
        rd(16'h0100, 32'h0, "unmapped_word");
        end_sim();
    end

endmodule
